// File: gss_pkg.sv
// Purpose: constants for the game status SPI slave
// Assumes: byte framing with most significant bit first
// Notes: command codes and reply layouts used by the slave design file only
package gss_pkg;
	// ==========================================
	// Framing
	localparam int unsigned GSS_BYTE_W = 8;
	localparam logic [7:0] GSS_CMD_BYTE_FILL = 8'h00;
	localparam logic [7:0] GSS_SECOND_BYTE = 8'hff;
	localparam logic [7:0] GSS_IDLE_BYTE = 8'h00;
	// ==========================================
	// Command codes
	localparam logic [7:0] GSS_CMD_TEAM_INFO = 8'hd2;
	localparam logic [7:0] GSS_CMD_RECYCLE_SCORE = 8'hb4;
	localparam logic [7:0] GSS_CMD_GAME_STATUS = 8'h78;
	localparam logic [7:0] GSS_CMD_ITEM_VALUE = 8'h69;
	// Registration byte layout
	localparam int unsigned GSS_REG_TEAM_BIT = 0;
	localparam int unsigned GSS_REG_TEAM_N_BIT = 5;
	localparam logic [7:0] GSS_REG_FIELD_MASK = 8'h21;
	// Registration reply layout
	localparam logic [3:0] GSS_ACK_UPPER = 4'ha;
	localparam int unsigned GSS_ACK_TEAM_BIT = 1;
	localparam int unsigned GSS_ACK_OK_BIT = 0;
	// Reply byte counts after the second byte
	localparam int unsigned GSS_SCORE_BYTES = 4;
	// ==========================================
	// Timing
	localparam int unsigned GSS_SYNC_STAGES = 2;
	localparam int unsigned GSS_CLK_PERIOD_NS = 8;
	localparam int unsigned GSS_IDLE_GAP_MS = 2;
	localparam int unsigned GSS_IDLE_GAP_CYC = GSS_IDLE_GAP_MS * 1000000 / GSS_CLK_PERIOD_NS;
	// Transaction state
	typedef enum logic [1:0] {
		GSS_ST_IDLE,
		GSS_ST_CMD,
		GSS_ST_REPLY
	} gss_state_t;
endpackage

// File: gss_spi_master.sv
// Purpose: SPI master model for the slave pins
// Assumes: mode 0, msb first
// Notes: HALF is the half period in system cycles
`timescale 1ns/1ps
module gss_spi_master #(
	parameter int HALF = 5
) (
	input wire logic clk_i,
	input wire logic sdo_i,
	output logic sck_o = 1'b0,
	output logic sel_n_o = 1'b1,
	output logic sdi_o = 1'b0
);
	// ========
	// Frame driver
	task automatic step();
		repeat (HALF) @(posedge clk_i);
		#1;
	endtask
	task automatic xfer(input logic [7:0] cmd, input int n, output logic [7:0] rx [8]);
		logic [7:0] tx;
		tx = cmd;
		step();
		sel_n_o = 1'b0;
		for (int b = 0; b < n; b++) begin
			for (int i = 7; i >= 0; i--) begin
				step();
				sck_o = 1'b0;
				sdi_o = tx[i];
				step();
				rx[b][i] = sdo_i;
				sck_o = 1'b1;
			end
			tx = 8'h00;
		end
		step();
		sck_o = 1'b0;
		step();
		sel_n_o = 1'b1;
	endtask
endmodule

// File: gss_spi_props.sv
// Purpose: port checks for the SPI slave
// Assumes: pins change off the clock edge
// Notes: select is seen at the raw pin
`timescale 1ns/1ps
module gss_spi_props (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	// Pins and status
	input wire logic spi_sel_n_i,
	input wire logic spi_sdo_o,
	input wire logic spi_sdo_oe_o,
	input wire logic cmd_valid_o,
	input wire logic [7:0] cmd_code_o,
	input wire logic reg_valid_o,
	input wire logic reg_team_o,
	input wire logic reg_ok_o,
	input wire logic gap_short_o
);
	// ========
	// Port relations
	default clocking @(posedge clk_sys_i);
	endclocking
	default disable iff (sys_rst_i);
	property p_oe_off;
		spi_sel_n_i [*4] |-> !spi_sdo_oe_o;
	endproperty
	a_oe_off: assert property (p_oe_off) else $error("oe on while idle");
	property p_oe_on;
		!spi_sel_n_i [*5] |-> spi_sdo_oe_o;
	endproperty
	a_oe_on: assert property (p_oe_on) else $error("oe off while selected");
	property p_sdo_idle;
		!spi_sdo_oe_o |-> !spi_sdo_o;
	endproperty
	a_sdo_idle: assert property (p_sdo_idle) else $error("sdo high while idle");
	property p_cmd_pulse;
		cmd_valid_o |=> !cmd_valid_o;
	endproperty
	a_cmd_pulse: assert property (p_cmd_pulse) else $error("command pulse too long");
	property p_code_hold;
		!cmd_valid_o |-> $stable(cmd_code_o);
	endproperty
	a_code_hold: assert property (p_code_hold) else $error("code changed alone");
	property p_reg_kind;
		reg_valid_o |-> cmd_valid_o && !(cmd_code_o inside {8'hd2, 8'hb4, 8'h78, 8'h69});
	endproperty
	a_reg_kind: assert property (p_reg_kind) else $error("known code taken as registration");
	property p_reg_fields;
		reg_valid_o |-> reg_team_o == cmd_code_o[0] &&
			reg_ok_o == ((cmd_code_o & 8'hde) == 8'h00 && cmd_code_o[5] != cmd_code_o[0]);
	endproperty
	a_reg_fields: assert property (p_reg_fields) else $error("registration fields wrong");
	property p_gap_pulse;
		gap_short_o |=> !gap_short_o;
	endproperty
	a_gap_pulse: assert property (p_gap_pulse) else $error("gap pulse too long");
endmodule
bind gss_spi_slave gss_spi_props i_gss_spi_props (.clk_sys_i, .sys_rst_i, .spi_sel_n_i, .spi_sdo_o, .spi_sdo_oe_o,
	.cmd_valid_o, .cmd_code_o, .reg_valid_o, .reg_team_o, .reg_ok_o, .gap_short_o);

// File: gss_spi_slave.sv
// Purpose: game status SPI slave, command byte in, reply bytes out
// Assumes: mode 0 (sample on rising, shift on falling), msb first
// Notes: reply data comes from user inputs sampled at byte boundaries
// Behaviour
// - Slave only; never drives the clock; data in on input, out on output.
// - A transaction has a variable byte count set by the command.
// - First byte received in each transaction is the command code.
// - Gateway shifts out zero while the command byte arrives.
// - Later output bytes carry the result of the received command.
// - Select is active low and idles deasserted when undriven.
// - Commands: registration, 0xd2, 0xb4, 0x78, 0x69.
// - Second output byte is all ones; real replies start at byte three.
// - Registration: team in bit 0, its complement in bit 5, rest zero.
// - Registration reply: upper 1010, bit 1 team, bit 0 success.
`timescale 1ns/1ps
module gss_spi_slave
	import gss_pkg::*;
#(
	parameter int unsigned GAP_CYC = gss_pkg::GSS_IDLE_GAP_CYC
) (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	// SPI pins
	input wire logic spi_sck_i,
	input wire logic spi_sel_n_i,
	input wire logic spi_sdi_i,
	output logic spi_sdo_o,
	output logic spi_sdo_oe_o,
	// Reply data from the game logic
	input wire logic [7:0] team_info_i,
	input wire logic [31:0] recycling_score_reply_i,
	input wire logic [7:0] game_status_i,
	input wire logic [7:0] recycled_item_value_reply_i,
	// Status to the game logic
	output logic cmd_valid_o,
	output logic [7:0] cmd_code_o,
	output logic reg_valid_o,
	output logic reg_team_o,
	output logic reg_ok_o,
	output logic gap_short_o
);
	import gss_pkg::*;

	// ==========================================
	// Pin synchronisers
	logic [2:0] pins_s;
	logic sck_s;
	logic sel_n_s;
	logic sdi_s;

	gss_sync #(
		.WIDTH(3),
		.RST_VAL(3'b010)
	) u_sync (
		.clk_sys_i(clk_sys_i),
		.sys_rst_i(sys_rst_i),
		.async_i({spi_sck_i, spi_sel_n_i, spi_sdi_i}),
		.sync_o(pins_s)
	);
	assign sck_s = pins_s[2];
	assign sel_n_s = pins_s[1];
	assign sdi_s = pins_s[0];

	// ==========================================
	// Edge detect
	logic sck_q, sck_d;
	logic sel_n_q, sel_n_d;
	logic sck_rise, sck_fall, sel_fall;
	assign sck_rise = sck_s & ~sck_q;
	assign sck_fall = ~sck_s & sck_q;
	assign sel_fall = ~sel_n_s & sel_n_q;

	// ==========================================
	// Transaction state
	gss_state_t st_q, st_d;
	logic [7:0] rx_q, rx_d;
	logic [7:0] tx_q, tx_d;
	logic [2:0] bit_q, bit_d;
	logic [7:0] cmd_q, cmd_d;
	logic [2:0] idx_q, idx_d;
	logic [31:0] gap_q, gap_d;
	logic sdo_q, sdo_d;
	logic oe_q, oe_d;
	logic cmd_valid_q, cmd_valid_d;
	logic reg_valid_q, reg_valid_d;
	logic reg_team_q, reg_team_d;
	logic reg_ok_q, reg_ok_d;
	logic gap_short_q, gap_short_d;
	logic [7:0] rx_full;
	logic [7:0] reply;
	logic reg_fmt_ok;

	// Byte for exchange idx (2 = first real reply byte)
	always_comb begin
		reply = GSS_IDLE_BYTE;
		reg_fmt_ok = ((cmd_q & ~GSS_REG_FIELD_MASK) == 8'h00) &&
			(cmd_q[GSS_REG_TEAM_N_BIT] == ~cmd_q[GSS_REG_TEAM_BIT]);
		if (idx_q == 3'd1) begin
			reply = GSS_SECOND_BYTE;
		end else begin
			case (cmd_q)
			GSS_CMD_TEAM_INFO: begin
				reply = team_info_i;
			end
			GSS_CMD_RECYCLE_SCORE: begin
				case (idx_q)
				3'd2: reply = recycling_score_reply_i[31:24];
				3'd3: reply = recycling_score_reply_i[23:16];
				3'd4: reply = recycling_score_reply_i[15:8];
				3'd5: reply = recycling_score_reply_i[7:0];
				default: reply = GSS_IDLE_BYTE;
				endcase
			end
			GSS_CMD_GAME_STATUS: begin
				reply = game_status_i;
			end
			GSS_CMD_ITEM_VALUE: begin
				reply = recycled_item_value_reply_i;
			end
			default: begin
				if (reg_fmt_ok) begin
					reply = {GSS_ACK_UPPER, 2'b00, cmd_q[GSS_REG_TEAM_BIT], 1'b1};
				end else begin
					reply = {GSS_ACK_UPPER, 4'b0000};
				end
			end
			endcase
		end
	end

	always_comb begin
		st_d = st_q;
		rx_d = rx_q;
		tx_d = tx_q;
		bit_d = bit_q;
		cmd_d = cmd_q;
		idx_d = idx_q;
		sdo_d = sdo_q;
		oe_d = ~sel_n_s;
		sck_d = sck_s;
		sel_n_d = sel_n_s;
		cmd_valid_d = 1'b0;
		reg_valid_d = 1'b0;
		reg_team_d = reg_team_q;
		reg_ok_d = reg_ok_q;
		gap_short_d = 1'b0;
		gap_d = (gap_q < GAP_CYC) ? gap_q + 32'd1 : gap_q;
		rx_full = {rx_q[6:0], sdi_s};
		if (sel_n_s) begin
			st_d = GSS_ST_IDLE;
			sdo_d = 1'b0;
		end else begin
			gap_d = 32'd0;
		end
		if (sel_fall) begin
			st_d = GSS_ST_CMD;
			bit_d = 3'd0;
			idx_d = 3'd0;
			tx_d = {GSS_CMD_BYTE_FILL[6:0], 1'b0};
			sdo_d = GSS_CMD_BYTE_FILL[7];
			gap_short_d = (gap_q < GAP_CYC);
		end else if (st_q != GSS_ST_IDLE && !sel_n_s) begin
			if (sck_rise) begin
				rx_d = rx_full;
				bit_d = bit_q + 3'd1;
				if (bit_q == 3'd7) begin
					if (st_q == GSS_ST_CMD) begin
						cmd_d = rx_full;
						cmd_valid_d = 1'b1;
						st_d = GSS_ST_REPLY;
						if (!(rx_full inside {GSS_CMD_TEAM_INFO, GSS_CMD_RECYCLE_SCORE,
							GSS_CMD_GAME_STATUS, GSS_CMD_ITEM_VALUE})) begin
							reg_valid_d = 1'b1;
							reg_ok_d = ((rx_full & ~GSS_REG_FIELD_MASK) == 8'h00) &&
								(rx_full[GSS_REG_TEAM_N_BIT] == ~rx_full[GSS_REG_TEAM_BIT]);
							reg_team_d = rx_full[GSS_REG_TEAM_BIT];
						end
					end
					if (idx_q != 3'd7) begin
						idx_d = idx_q + 3'd1;
					end
				end
			end else if (sck_fall) begin
				if (bit_q == 3'd0) begin
					sdo_d = reply[7];
					tx_d = {reply[6:0], 1'b0};
				end else begin
					sdo_d = tx_q[7];
					tx_d = {tx_q[6:0], 1'b0};
				end
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			st_q <= GSS_ST_IDLE;
			rx_q <= 8'h00;
			tx_q <= 8'h00;
			bit_q <= 3'd0;
			cmd_q <= 8'h00;
			idx_q <= 3'd0;
			gap_q <= 32'd0;
			sdo_q <= 1'b0;
			oe_q <= 1'b0;
			sck_q <= 1'b0;
			sel_n_q <= 1'b1;
			cmd_valid_q <= 1'b0;
			reg_valid_q <= 1'b0;
			reg_team_q <= 1'b0;
			reg_ok_q <= 1'b0;
			gap_short_q <= 1'b0;
		end else begin
			st_q <= st_d;
			rx_q <= rx_d;
			tx_q <= tx_d;
			bit_q <= bit_d;
			cmd_q <= cmd_d;
			idx_q <= idx_d;
			gap_q <= gap_d;
			sdo_q <= sdo_d;
			oe_q <= oe_d;
			sck_q <= sck_d;
			sel_n_q <= sel_n_d;
			cmd_valid_q <= cmd_valid_d;
			reg_valid_q <= reg_valid_d;
			reg_team_q <= reg_team_d;
			reg_ok_q <= reg_ok_d;
			gap_short_q <= gap_short_d;
		end
	end

	// ==========================================
	// Outputs
	assign spi_sdo_o = sdo_q;
	assign spi_sdo_oe_o = oe_q;
	assign cmd_valid_o = cmd_valid_q;
	assign cmd_code_o = cmd_q;
	assign reg_valid_o = reg_valid_q;
	assign reg_team_o = reg_team_q;
	assign reg_ok_o = reg_ok_q;
	assign gap_short_o = gap_short_q;
endmodule

// File: gss_sync.sv
// Purpose: two flip-flop synchroniser for a group of pins
// Assumes: inputs are asynchronous to clk_sys_i
// Notes: reset value is a parameter so select settles high
`timescale 1ns/1ps
module gss_sync #(
	parameter int unsigned WIDTH = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	// Pins
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] meta_d;
	logic [WIDTH-1:0] sync_q;
	logic [WIDTH-1:0] sync_d;

	always_comb begin
		meta_d = async_i;
		sync_d = meta_q;
	end

	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			meta_q <= RST_VAL;
			sync_q <= RST_VAL;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign sync_o = sync_q;
endmodule

// File: tb_gss_spi_slave.sv
// Purpose: self-checking bench for the SPI slave
// Assumes: short idle gap for speed
// Notes: reply inputs drawn at random per frame
`timescale 1ns/1ps
module tb_gss_spi_slave;
	localparam int GAPC = 50;
	logic clk_sys_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic sck, sel_n, sdi, sdo, oe, cv, rv, rteam, rok, gs;
	logic [7:0] team = 8'h00, stat = 8'h00, item = 8'h00, ccode;
	logic [31:0] score = 32'h0;
	logic [63:0] list = 64'hd2b4786901202100;
	logic [7:0] rx [8];
	int num_errors = 0, samples_checked = 0, gaps = 0, cvs = 0, rvs = 0;
	wire sdo_w = oe ? sdo : ~sdo;
	gss_spi_slave #(.GAP_CYC(GAPC)) i_gss_spi_slave (.clk_sys_i, .sys_rst_i, .spi_sck_i(sck), .spi_sel_n_i(sel_n),
		.spi_sdi_i(sdi), .spi_sdo_o(sdo), .spi_sdo_oe_o(oe), .team_info_i(team), .recycling_score_reply_i(score),
		.game_status_i(stat), .recycled_item_value_reply_i(item), .cmd_valid_o(cv), .cmd_code_o(ccode),
		.reg_valid_o(rv), .reg_team_o(rteam), .reg_ok_o(rok), .gap_short_o(gs));
	gss_spi_master i_gss_spi_master (.clk_i(clk_sys_i), .sdo_i(sdo_w), .sck_o(sck), .sel_n_o(sel_n), .sdi_o(sdi));
	// ========
	// Helpers
	initial begin
		forever #4 clk_sys_i = ~clk_sys_i;
	end
	always @(posedge clk_sys_i) begin
		if (gs === 1'b1) gaps <= gaps + 1;
		if (cv === 1'b1) cvs <= cvs + 1;
		if (rv === 1'b1) rvs <= rvs + 1;
	end
	function automatic logic wf(logic [7:0] c);
		return (c & 8'hde) == 8'h00 && c[5] != c[0];
	endfunction
	function automatic logic [7:0] exp_byte(logic [7:0] c, int b);
		if (b == 0) return 8'h00;
		if (b == 1) return 8'hff;
		case (c)
			8'hd2: return team;
			8'hb4: return (b < 6) ? score[8*(5-b) +: 8] : 8'h00;
			8'h78: return stat;
			8'h69: return item;
			default: return wf(c) ? {4'ha, 2'b00, c[0], 1'b1} : 8'ha0;
		endcase
	endfunction
	task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %s exp %h seen %h", what, exp, seen);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// ========
	// Tests
	initial begin
		logic [7:0] c;
		int n;
		int cv0;
		int rv0;
		void'($urandom(32'h11b2));
		repeat (12) @(posedge clk_sys_i);
		#1;
		sys_rst_i = 1'b0;
		repeat (GAPC + 10) @(posedge clk_sys_i);
		#1;
		for (int k = 0; k < 10; k++) begin
			c = (k < 8) ? list[63-8*k -: 8] : 8'($urandom);
			team = 8'($urandom);
			stat = 8'($urandom);
			item = 8'($urandom);
			score = $urandom;
			n = (c == 8'hb4) ? 8 : 4;
			cv0 = cvs;
			rv0 = rvs;
			i_gss_spi_master.xfer(c, n, rx);
			for (int b = 0; b < n; b++) check("reply", rx[b], exp_byte(c, b));
			check("code", ccode, c);
			check("cmd pulses", 8'(cvs - cv0), 8'd1);
			check("reg pulses", 8'(rvs - rv0), (c inside {8'hd2, 8'hb4, 8'h78, 8'h69}) ? 8'd0 : 8'd1);
			if (!(c inside {8'hd2, 8'hb4, 8'h78, 8'h69})) begin
				check("team", 8'(rteam), 8'(c[0]));
				check("ok", 8'(rok), 8'(wf(c)));
			end
			$display("test %0d done", k);
			repeat (GAPC + 10) @(posedge clk_sys_i);
			#1;
		end
		check("gaps", 8'(gaps), 8'd0);
		cv0 = cvs;
		i_gss_spi_master.xfer(8'h78, 3, rx);
		i_gss_spi_master.xfer(8'h78, 3, rx);
		repeat (10) @(posedge clk_sys_i);
		check("gaps", 8'(gaps), 8'd1);
		check("cmd pulses", 8'(cvs - cv0), 8'd2);
		check("reply", rx[2], stat);
		$display("test short gap done");
		report_and_stop();
	end
	initial begin
		repeat (40000) @(posedge clk_sys_i);
		num_errors++;
		report_and_stop();
	end
endmodule
